/* File: hdl/edge_pulse_counter.sv */
// Purpose: counts rising edges, free running or per gate window
// Assumes: level input already synchronised to clk
// Notes: GATE_CYCLES of zero means a running total
`timescale 1ns/100ps
module edge_pulse_counter #(
	parameter int WIDTH = 32,
	parameter int GATE_CYCLES = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic level,
	input wire logic clear,
	output logic [WIDTH-1:0] count
);
	import terminal_status_pkg::*;

	logic prev_reg;
	logic [WIDTH-1:0] acc_reg;
	logic [WIDTH-1:0] count_reg;
	logic [31:0] gate_reg;
	logic edge_seen;

	assign edge_seen = level && !prev_reg;
	assign count = count_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
			prev_reg <= 1'b0;
		else
			prev_reg <= level;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gate_reg <= 32'h0;
			acc_reg <= '0;
			count_reg <= '0;
		end
		else if (GATE_CYCLES == 0)
		begin
			// an edge in the clear cycle still counts
			if (clear)
				count_reg <= WIDTH'(edge_seen);
			else
				count_reg <= count_reg + WIDTH'(edge_seen);
		end
		else if (gate_reg == 32'(GATE_CYCLES - 1))
		begin
			gate_reg <= 32'h0;
			count_reg <= acc_reg + WIDTH'(edge_seen);
			acc_reg <= '0;
		end
		else
		begin
			gate_reg <= gate_reg + 32'h1;
			acc_reg <= acc_reg + WIDTH'(edge_seen);
		end
	end

endmodule

/* File: hdl/hex_glyph.sv */
// Purpose: one nibble to one seven-segment glyph
// Assumes: segments active high
// Notes: purely combinational
`timescale 1ns/100ps
module hex_glyph
	import terminal_status_pkg::*;
(
	input wire logic [terminal_status_pkg::NIB_W-1:0] nibble,
	output logic [terminal_status_pkg::SEG_W-1:0] segments
);
	import terminal_status_pkg::*;

	always_comb
	begin
		segments = GLYPH_TABLE[nibble*SEG_W +: SEG_W];
	end

endmodule

/* File: hdl/terminal_status_display.sv */
// Purpose: terminal states to a four-digit seven-segment display
// Assumes: terminal pins asynchronous, run flags on clk
// Notes: registers over Avalon-MM, one answer per two cycles
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps

module terminal_status_display #(
	parameter int RATE_GATE = terminal_status_pkg::RATE_GATE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [terminal_status_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [terminal_status_pkg::DATA_W-1:0] avs_writedata,
	output logic [terminal_status_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic forward_run_input,
	input wire logic reverse_run_input,
	input wire logic [5:0] multifunction_inputs,
	input wire logic pulse_train_input,
	input wire logic transistor_output_a,
	input wire logic transistor_output_b,
	input wire logic relay_contact,
	input wire logic pulse_output,
	input wire logic rotating_forward_flag,
	input wire logic rotating_reverse_flag,
	input wire logic alarm_active_flag,
	input wire logic param_write_flag,
	output logic [terminal_status_pkg::SEG_W-1:0] digit_rightmost,
	output logic [terminal_status_pkg::SEG_W-1:0] digit_second,
	output logic [terminal_status_pkg::SEG_W-1:0] digit_third,
	output logic [terminal_status_pkg::SEG_W-1:0] digit_leftmost
);
	import terminal_status_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] sync_1_reg;
	logic [PIN_W-1:0] sync_2_reg;
	logic [WORD_W-1:0] input_word_reg;
	logic [WORD_W-1:0] input_word_next;
	logic [WORD_W-1:0] output_word_reg;
	logic [WORD_W-1:0] output_word_next;
	logic [WORD_W-1:0] run_word_reg;
	logic [WORD_W-1:0] run_word_next;
	logic [WORD_W-1:0] shown_word;
	logic [CTRL_W-1:0] ctrl_reg;
	logic hex_style;
	logic [1:0] word_sel;
	logic [COUNT_W-1:0] pulse_count;
	logic [COUNT_W-1:0] pulse_rate;
	logic count_clear;
	logic [DIGITS*SEG_W-1:0] glyph_seg;
	logic [DIGITS*SEG_W-1:0] bar_seg;
	logic [DIGITS*SEG_W-1:0] seg_next;
	logic [DIGITS*SEG_W-1:0] seg_reg;
	logic any_active;
	bus_state_e bus_state_reg;
	logic wait_reg;
	logic [DATA_W-1:0] readdata_reg;
	logic [DATA_W-1:0] read_mux;
	logic bus_req;
	logic bus_take;

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	assign pins_raw = {pulse_output, relay_contact, transistor_output_b, transistor_output_a,
		pulse_train_input, multifunction_inputs, reverse_run_input, forward_run_input};

	// first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_1_reg <= '0;
			sync_2_reg <= '0;
		end
		else
		begin
			sync_1_reg <= pins_raw;
			sync_2_reg <= sync_1_reg;
		end
	end

	// ----------------------------------------------------------------
	// status words
	// ----------------------------------------------------------------
	always_comb
	begin
		input_word_next = '0;
		input_word_next[IN_FWD_BIT] = sync_2_reg[PIN_FWD];
		input_word_next[IN_REV_BIT] = sync_2_reg[PIN_REV];
		input_word_next[IN_MI_HI:IN_MI_LO] = sync_2_reg[PIN_MI_HI:PIN_MI_LO];
	end

	always_comb
	begin
		output_word_next = '0;
		output_word_next[OUT_MO_A_BIT] = sync_2_reg[PIN_MO_A];
		output_word_next[OUT_MO_B_BIT] = sync_2_reg[PIN_MO_B];
		output_word_next[OUT_RELAY_BIT] = sync_2_reg[PIN_RELAY];
	end

	always_comb
	begin
		run_word_next = '0;
		run_word_next[RUN_FWD_BIT] = rotating_forward_flag;
		run_word_next[RUN_REV_BIT] = rotating_reverse_flag;
		run_word_next[RUN_ALARM_BIT] = alarm_active_flag;
		run_word_next[RUN_BUSY_BIT] = param_write_flag;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			input_word_reg <= '0;
			output_word_reg <= '0;
			run_word_reg <= '0;
		end
		else
		begin
			input_word_reg <= input_word_next;
			output_word_reg <= output_word_next;
			run_word_reg <= run_word_next;
		end
	end

	// ----------------------------------------------------------------
	// pulse counters
	// ----------------------------------------------------------------
	edge_pulse_counter #(
		.WIDTH(COUNT_W),
		.GATE_CYCLES(0)
	) u_pulse_in (
		.clk(clk),
		.rst(rst),
		.level(sync_2_reg[PIN_MI_HI]),
		.clear(count_clear),
		.count(pulse_count)
	);

	// one-second gate gives pulses per second directly
	edge_pulse_counter #(
		.WIDTH(COUNT_W),
		.GATE_CYCLES(RATE_GATE)
	) u_pulse_rate (
		.clk(clk),
		.rst(rst),
		.level(sync_2_reg[PIN_PULSE_OUT]),
		.clear(1'b0),
		.count(pulse_rate)
	);

	// ----------------------------------------------------------------
	// display
	// ----------------------------------------------------------------
	assign hex_style = ctrl_reg[CTRL_HEX_BIT];
	assign word_sel = ctrl_reg[CTRL_SEL_LO +: 2];

	always_comb
	begin
		case (word_sel)
			SEL_INPUT: shown_word = input_word_reg;
			SEL_OUTPUT: shown_word = output_word_reg;
			SEL_RUN: shown_word = run_word_reg;
			default: shown_word = pulse_count[WORD_W-1:0];
		endcase
	end

	// digit 0 is rightmost, digit 3 leftmost
	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++)
		begin : g_glyph
			hex_glyph u_glyph (
				.nibble(shown_word[gi*NIB_W +: NIB_W]),
				.segments(glyph_seg[gi*SEG_W +: SEG_W])
			);
		end
	endgenerate

	// mi5 and mi6 have no segment but still count as active
	assign any_active = (|input_word_reg) || (|output_word_reg);

	always_comb
	begin
		bar_seg = '0;
		bar_seg[SEG_A] = input_word_reg[IN_FWD_BIT];
		bar_seg[SEG_B] = input_word_reg[IN_REV_BIT];
		bar_seg[SEG_C] = input_word_reg[IN_MI_LO];
		bar_seg[SEG_D] = input_word_reg[IN_MI_LO+1];
		bar_seg[SEG_E] = input_word_reg[IN_MI_LO+2];
		bar_seg[SEG_F] = input_word_reg[IN_MI_LO+3];
		bar_seg[SEG_W+SEG_A] = input_word_reg[IN_MI_HI];
		bar_seg[2*SEG_W+SEG_A] = output_word_reg[OUT_MO_A_BIT];
		bar_seg[2*SEG_W+SEG_B] = output_word_reg[OUT_MO_B_BIT];
		bar_seg[3*SEG_W+SEG_A] = output_word_reg[OUT_RELAY_BIT];
		if (!any_active)
			bar_seg = {DIGITS{SEG_DASH}};
	end

	always_comb
	begin
		if (hex_style)
			seg_next = glyph_seg;
		else
			seg_next = bar_seg;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			seg_reg <= {DIGITS{SEG_BLANK}};
		else
			seg_reg <= seg_next;
	end

	assign digit_rightmost = seg_reg[0 +: SEG_W];
	assign digit_second = seg_reg[SEG_W +: SEG_W];
	assign digit_third = seg_reg[2*SEG_W +: SEG_W];
	assign digit_leftmost = seg_reg[3*SEG_W +: SEG_W];

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	// fixed two-cycle answer keeps the read mux off the bus path
	assign bus_req = avs_read || avs_write;
	assign bus_take = (bus_state_reg == BUS_ANSWER);
	assign avs_waitrequest = wait_reg;
	assign avs_readdata = readdata_reg;
	assign count_clear = bus_take && avs_write && avs_byteenable[0]
		&& (avs_address == OFS_COUNT_CLEAR) && avs_writedata[CLEAR_BIT];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bus_state_reg <= BUS_IDLE;
			wait_reg <= 1'b1;
		end
		else
		begin
			case (bus_state_reg)
				BUS_IDLE:
				begin
					if (bus_req)
					begin
						bus_state_reg <= BUS_ANSWER;
						wait_reg <= 1'b0;
					end
				end
				BUS_ANSWER:
				begin
					bus_state_reg <= BUS_IDLE;
					wait_reg <= 1'b1;
				end
				default:
				begin
					bus_state_reg <= BUS_IDLE;
					wait_reg <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		read_mux = '0;
		case (avs_address)
			OFS_CTRL: read_mux[CTRL_W-1:0] = ctrl_reg;
			OFS_INPUT_WORD: read_mux[WORD_W-1:0] = input_word_reg;
			OFS_OUTPUT_WORD: read_mux[WORD_W-1:0] = output_word_reg;
			OFS_RUN_STATUS: read_mux[WORD_W-1:0] = run_word_reg;
			OFS_PULSE_COUNT: read_mux = pulse_count;
			OFS_PULSE_RATE: read_mux = pulse_rate;
			OFS_DISPLAY: read_mux = seg_reg;
			default: read_mux = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			readdata_reg <= '0;
		else if (bus_state_reg == BUS_IDLE && avs_read)
			readdata_reg <= read_mux;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl_reg <= CTRL_RESET;
		else if (bus_take && avs_write && avs_byteenable[0] && avs_address == OFS_CTRL)
			ctrl_reg <= avs_writedata[CTRL_W-1:0];
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_fwd_rev_bits: assert property (
		##1 input_word_reg[1:0] == $past(sync_2_reg[1:0]))
		else $error("forward or reverse bit misplaced");
	a_multi_bits: assert property (
		##1 input_word_reg[8:2] == $past(sync_2_reg[8:2]))
		else $error("multifunction bits misplaced");
	a_on_reads_one: assert property (
		$rose(sync_2_reg[PIN_FWD]) |=> input_word_reg[IN_FWD_BIT])
		else $error("forward on did not read as one");
	a_unused_zero: assert property (
		input_word_reg[15:9] == 7'h00 && output_word_reg[15:9] == 7'h00
		&& output_word_reg[7:2] == 6'h00)
		else $error("unassigned status bit set");
	a_hex_leftmost: assert property (
		hex_style && shown_word[15:12] == 4'h8 |=> digit_leftmost == 8'h7F)
		else $error("leftmost digit not top nibble glyph");
	a_out_bits: assert property (
		##1 output_word_reg[1:0] == $past(sync_2_reg[10:9]))
		else $error("transistor output bits misplaced");
	a_relay_bit: assert property (
		$rose(sync_2_reg[PIN_RELAY]) |=> output_word_reg[OUT_RELAY_BIT])
		else $error("relay bit not set when closed");
	a_glyph_ten: assert property (
		hex_style && shown_word[3:0] == 4'hA |=> digit_rightmost == 8'h77)
		else $error("value ten not shown as A");
	a_bar_inputs: assert property (
		!hex_style && any_active |=> digit_rightmost[5:0] == $past(input_word_reg[5:0]))
		else $error("input segments wrong");
	a_bar_outputs: assert property (
		!hex_style && any_active |=> digit_third[1:0] == $past(output_word_reg[1:0]))
		else $error("transistor output segments wrong");
	a_bar_relay: assert property (
		!hex_style && output_word_reg[OUT_RELAY_BIT] |=> digit_leftmost[SEG_A])
		else $error("relay segment dark while closed");
	a_four_dashes: assert property (
		!hex_style && !any_active |=> seg_reg == {DIGITS{SEG_DASH}})
		else $error("dashes missing when idle");
	a_count_step: assert property (
		sync_2_reg[PIN_MI_HI] && !$past(sync_2_reg[PIN_MI_HI]) && !count_clear
		|=> pulse_count == $past(pulse_count) + 32'h1)
		else $error("pulse edge not counted");
	a_run_alarm: assert property (
		alarm_active_flag |=> run_word_reg[RUN_ALARM_BIT])
		else $error("alarm bit not set");
	a_bus_answer: assert property (
		bus_req && wait_reg && bus_state_reg == BUS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

	c_hex_input: cover property (hex_style && word_sel == SEL_INPUT && |input_word_reg);
	c_dashes: cover property (!hex_style && !any_active ##1 seg_reg == {DIGITS{SEG_DASH}});
	c_rate_nonzero: cover property (pulse_rate != '0);
	c_ctrl_write: cover property (bus_take && avs_write && avs_address == OFS_CTRL);

endmodule

/* File: hdl/terminal_status_pkg.sv */
// Purpose: shared constants for the terminal status display
// Assumes: 32-bit Avalon-MM register bus, 20 MHz clock
// Notes: segment bit 0 is segment a, bit 6 is g, bit 7 is dp
package terminal_status_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int RATE_GATE_S = 1;
	localparam int RATE_GATE_CYCLES = RATE_GATE_S * CLK_HZ;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int SEG_W = 8;
	localparam int NIB_W = 4;
	localparam int DIGITS = 4;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 32;
	localparam int PIN_W = 13;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_INPUT_WORD = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_WORD = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_RUN_STATUS = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_PULSE_COUNT = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_PULSE_RATE = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_DISPLAY = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_COUNT_CLEAR = 5'h1C;

	// ----------------------------------------------------------------
	// control fields and word selections
	// ----------------------------------------------------------------
	localparam int CTRL_HEX_BIT = 0;
	localparam int CTRL_SEL_LO = 1;
	localparam int CTRL_W = 3;
	localparam int CLEAR_BIT = 0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] SEL_INPUT = 2'h0;
	localparam logic [1:0] SEL_OUTPUT = 2'h1;
	localparam logic [1:0] SEL_RUN = 2'h2;
	localparam logic [1:0] SEL_COUNT = 2'h3;

	// ----------------------------------------------------------------
	// synchronised pin vector positions
	// ----------------------------------------------------------------
	localparam int PIN_FWD = 0;
	localparam int PIN_REV = 1;
	localparam int PIN_MI_LO = 2;
	localparam int PIN_MI_HI = 8;
	localparam int PIN_MO_A = 9;
	localparam int PIN_MO_B = 10;
	localparam int PIN_RELAY = 11;
	localparam int PIN_PULSE_OUT = 12;

	// ----------------------------------------------------------------
	// status word bit positions
	// ----------------------------------------------------------------
	localparam int IN_FWD_BIT = 0;
	localparam int IN_REV_BIT = 1;
	localparam int IN_MI_LO = 2;
	localparam int IN_MI_HI = 8;
	localparam int OUT_MO_A_BIT = 0;
	localparam int OUT_MO_B_BIT = 1;
	localparam int OUT_RELAY_BIT = 8;
	localparam int RUN_FWD_BIT = 0;
	localparam int RUN_REV_BIT = 1;
	localparam int RUN_ALARM_BIT = 11;
	localparam int RUN_BUSY_BIT = 15;

	// ----------------------------------------------------------------
	// segments and glyphs
	// ----------------------------------------------------------------
	localparam int SEG_A = 0;
	localparam int SEG_B = 1;
	localparam int SEG_C = 2;
	localparam int SEG_D = 3;
	localparam int SEG_E = 4;
	localparam int SEG_F = 5;
	localparam int SEG_G = 6;
	localparam logic [SEG_W-1:0] SEG_DASH = 8'h40;
	localparam logic [SEG_W-1:0] SEG_BLANK = 8'h00;
	// entry n sits at bits [8n+7:8n]; digits 0-9 then A b c d E F
	localparam logic [16*SEG_W-1:0] GLYPH_TABLE = {
		8'h71, 8'h79, 8'h5E, 8'h58, 8'h7C, 8'h77, 8'h6F, 8'h7F,
		8'h07, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F};

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_e;

endpackage

/* File: test/display_model.sv */
// Purpose: four-digit seven-segment display as a reader sees it
// Assumes: segments active high, bit 0 is segment a
// Notes: a pattern that is no hex glyph reads as not ok
`timescale 1ns/100ps
module display_model
	import terminal_status_pkg::*;
(
	input wire logic [terminal_status_pkg::SEG_W-1:0] digit_rightmost,
	input wire logic [terminal_status_pkg::SEG_W-1:0] digit_second,
	input wire logic [terminal_status_pkg::SEG_W-1:0] digit_third,
	input wire logic [terminal_status_pkg::SEG_W-1:0] digit_leftmost,
	output logic [15:0] shown_value,
	output logic shown_ok
);
	// own copy, so a wrong design table cannot read back as right
	localparam logic [7:0] SHAPES [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
		8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h58, 8'h5E, 8'h79, 8'h71};
	logic [4:0] g0, g1, g2, g3;

	function automatic logic [4:0] read_glyph(input logic [7:0] s);
		for (int n = 0; n < 16; n++)
		begin
			if (SHAPES[n] === s)
			begin
				return {1'b0, 4'(n)};
			end
		end
		return 5'h10;
	endfunction

	assign g0 = read_glyph(digit_rightmost);
	assign g1 = read_glyph(digit_second);
	assign g2 = read_glyph(digit_third);
	assign g3 = read_glyph(digit_leftmost);
	// leftmost read as top nibble
	assign shown_value = {g3[3:0], g2[3:0], g1[3:0], g0[3:0]};
	assign shown_ok = !(g3[4] | g2[4] | g1[4] | g0[4]);
endmodule

/* File: test/terminal_status_display_tb.sv */
// Purpose: self-checking bench for the terminal status display
// Assumes: short rate gate of 100 cycles
// Notes: pin vector p: 8:0 inputs, 9-11 outputs, 12 pulse out, 16:13 run flags
`timescale 1ns/100ps
module terminal_status_display_tb;
	import terminal_status_pkg::*;
	localparam int GATE = 100;
	localparam logic [7:0] GLYPHS [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
		8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h58, 8'h5E, 8'h79, 8'h71};
	logic clk, rst, avs_read, avs_write, avs_waitrequest, shown_ok;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] d0, d1, d2, d3;
	logic [15:0] shown_value;
	logic [16:0] pv, p;
	integer n_errors, check_count, seed;

	terminal_status_display #(.RATE_GATE(GATE)) dut (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.forward_run_input(pv[0]), .reverse_run_input(pv[1]),
		.multifunction_inputs(pv[7:2]), .pulse_train_input(pv[8]),
		.transistor_output_a(pv[9]), .transistor_output_b(pv[10]),
		.relay_contact(pv[11]), .pulse_output(pv[12]),
		.rotating_forward_flag(pv[13]), .rotating_reverse_flag(pv[14]),
		.alarm_active_flag(pv[15]), .param_write_flag(pv[16]),
		.digit_rightmost(d0), .digit_second(d1), .digit_third(d2), .digit_leftmost(d3));

	display_model panel (.digit_rightmost(d0), .digit_second(d1), .digit_third(d2),
		.digit_leftmost(d3), .shown_value(shown_value), .shown_ok(shown_ok));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic [15:0] in_word(input logic [16:0] q);
		return {7'h00, q[8:0]};
	endfunction

	function automatic logic [15:0] out_word(input logic [16:0] q);
		return {7'h00, q[11], 6'h00, q[10:9]};
	endfunction

	function automatic logic [15:0] run_word(input logic [16:0] q);
		return {q[16], 3'h0, q[15], 9'h000, q[14:13]};
	endfunction

	// mi5 and mi6 have no segment but still cancel the dashes
	function automatic logic [31:0] seg_word(input logic [16:0] q);
		if (in_word(q) == 16'h0000 && out_word(q) == 16'h0000)
		begin
			return 32'h40404040;
		end
		return {7'h00, q[11], 6'h00, q[10:9], 7'h00, q[8], 2'h0, q[5:0]};
	endfunction

	// ----------------------------------------------------------------
	// checks and bus
	// ----------------------------------------------------------------
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_disp(input logic [15:0] exp);
		check_count++;
		if (shown_ok !== 1'b1 || shown_value !== exp)
		begin
			n_errors++;
			$display("Error at %0t: shown %h expected %h", $time, shown_value, exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// entered just after a rising edge; leaves one idle cycle behind
	task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
		if (n >= 40)
		begin
			n_errors++;
			$display("Error at %0t: no answer %h %h", $time, a, 32'h0);
			final_report();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus_xfer(1'b1, a, d, 4'hF);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0, 4'hF);
		cmp_reg(rd, exp);
	endtask

	// pins reach the digits four edges later
	task automatic set_pins(input logic [16:0] q);
		pv <= q;
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 28;
		n_errors = 0;
		check_count = 0;
		rst = 1'b1;
		pv = 17'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rdc(OFS_CTRL, 32'h0);
		set_pins(17'h0);
		cmp_reg({d3, d2, d1, d0}, 32'h40404040);
		for (int i = 0; i < 24; i++)
		begin
			p = (i == 0) ? 17'h00040 : (i == 1) ? 17'h1FFFF : 17'($random(seed));
			set_pins(p);
			cmp_reg({d3, d2, d1, d0}, seg_word(p));
			rdc(OFS_DISPLAY, seg_word(p));
			rdc(OFS_INPUT_WORD, {16'h0, in_word(p)});
			rdc(OFS_OUTPUT_WORD, {16'h0, out_word(p)});
			rdc(OFS_RUN_STATUS, {16'h0, run_word(p)});
			wr(OFS_CTRL, {29'h0, 2'(i % 3), 1'b1});
			repeat (8) @(posedge clk);
			cmp_disp(i % 3 == 0 ? in_word(p) : i % 3 == 1 ? out_word(p) : run_word(p));
			wr(OFS_CTRL, 32'h0);
		end
		wr(OFS_CTRL, 32'h1);
		for (int n = 0; n < 16; n++)
		begin
			set_pins(17'(n));
			cmp_reg({d3, d2, d1, d0}, {GLYPHS[0], GLYPHS[0], GLYPHS[0], GLYPHS[n]});
		end
		set_pins(17'h0);
		wr(OFS_COUNT_CLEAR, 32'h1);
		rdc(OFS_PULSE_COUNT, 32'h0);
		for (int k = 0; k < 37; k++)
		begin
			pv[8] <= 1'b1;
			repeat (3) @(posedge clk);
			pv[8] <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		rdc(OFS_PULSE_COUNT, 32'd37);
		wr(OFS_CTRL, 32'h7);
		repeat (8) @(posedge clk);
		cmp_disp(16'h0025);
		// lane 0 off: the clear must not land
		bus_xfer(1'b1, OFS_COUNT_CLEAR, 32'h1, 4'hE);
		rdc(OFS_PULSE_COUNT, 32'd37);
		wr(OFS_COUNT_CLEAR, 32'h1);
		rdc(OFS_PULSE_COUNT, 32'h0);
		// write-only clear word reads back as zero
		rdc(OFS_COUNT_CLEAR, 32'h0);
		// period of 10 cycles gives exactly GATE/10 edges in any window
		fork
			for (int k = 0; k < 30; k++)
			begin
				pv[12] <= 1'b1;
				repeat (5) @(posedge clk);
				pv[12] <= 1'b0;
				repeat (5) @(posedge clk);
			end
		join_none
		repeat (250) @(posedge clk);
		rdc(OFS_PULSE_RATE, GATE / 10);
		repeat (60) @(posedge clk);
		final_report();
	end
endmodule
